// *** design/pwm_top.sv ***
`timescale 1ns/100ps
module pwm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pwm_pkg::wb_req_s wb_i,
  output pwm_pkg::wb_rsp_s wb_o,
  input wire logic [7:0] p1_i,
  output logic [7:0] p1_o,
  output logic [7:0] p1_oe_n_o,
  input wire logic [7:0] gpio_out_i,
  input wire logic [7:0] gpio_oe_n_i,
  output logic [7:0] gpio_in_o,
  output logic ale_o
);
  import pwm_pkg::*;

  typedef struct packed {
    bus_state_e bus;
    logic [31:0] rdat;
    logic [7:0] pinsel;
    logic inhibit;
    ch_ctrl_s [NUM_CH-1:0] ctrl;
    logic [NUM_CH-1:0][7:0] duty;
    logic [2:0] div;
    logic [3:0] ale_cnt;
    logic ale;
    logic [7:0] p1o;
    logic [7:0] p1oe_n;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } top_state_s;

  top_state_s q;
  top_state_s n;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [NUM_CH-1:0] tick_w;
  logic [NUM_CH-1:0] pwm_w;

  // one shared divider keeps all channels of equal prescale in phase
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign tick_w[g] = (q.div & PRE_MASK[q.ctrl[g].pre]) == 3'h0;
      pwm_channel u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_w[g]),
        .ctrl_i(q.ctrl[g]),
        .duty_i(q.duty[g]),
        .pwm_o(pwm_w[g])
      );
    end
  endgenerate

  always_comb begin
    n = q;
    idx = wb_i.adr[9:2];
    req = wb_i.cyc && wb_i.stb && (q.bus == BUS_IDLE);
    wr = req && wb_i.we && wb_i.sel[0];
    n.bus = req ? BUS_ACK : BUS_IDLE;
    n.rdat = 32'h0;
    // unmapped index acks with zero data and drops the write
    if (idx == IDX_PINSEL) begin
      n.rdat[7:0] = q.pinsel;
      if (wr) begin
        n.pinsel = wb_i.dat[7:0];
      end
    end else if (idx == IDX_SYSCTL) begin
      n.rdat[INHIBIT_BIT] = q.inhibit;
      if (wr) begin
        n.inhibit = wb_i.dat[INHIBIT_BIT];
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (idx == IDX_CTRL[i]) begin
          n.rdat[RES_BIT] = q.ctrl[i].res5;
          n.rdat[PRE_MSB:PRE_LSB] = q.ctrl[i].pre;
          if (wr) begin
            n.ctrl[i].res5 = wb_i.dat[RES_BIT];
            n.ctrl[i].pre = wb_i.dat[PRE_MSB:PRE_LSB];
          end
        end else if (idx == IDX_DUTY[i]) begin
          n.rdat[7:0] = q.duty[i];
          if (wr) begin
            n.duty[i] = wb_i.dat[7:0];
          end
        end
      end
    end
    n.div = q.div + 3'h1;
    n.ale_cnt = (q.ale_cnt == ALE_PERIOD_LAST) ? 4'h0 : q.ale_cnt + 4'h1;
    n.ale = (q.ale_cnt < ALE_HIGH_CYC) && !q.inhibit;
    for (int i = 0; i < NUM_CH; i++) begin
      n.p1o[i] = q.pinsel[i] ? pwm_w[i] : gpio_out_i[i];
      n.p1oe_n[i] = q.pinsel[i] ? 1'b0 : gpio_oe_n_i[i];
    end
    n.sync1 = p1_i;
    n.sync2 = q.sync1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.bus <= BUS_IDLE;
      q.pinsel <= PINSEL_RST;
      q.inhibit <= INHIBIT_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        q.ctrl[i].res5 <= RES_RST;
        q.ctrl[i].pre <= PRE_RST;
        q.duty[i] <= DUTY_RST;
      end
      q.p1oe_n <= 8'hff;
    end else begin
      q <= n;
    end
  end

  assign wb_o.ack = q.bus == BUS_ACK;
  assign wb_o.dat = q.rdat;
  assign p1_o = q.p1o;
  assign p1_oe_n_o = q.p1oe_n;
  assign gpio_in_o = q.sync2;
  assign ale_o = q.ale;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strobe_off_a: assert property (q.inhibit |=> !ale_o)
    else $error("strobe driven while inhibited");
  // judged one cycle at a time, so that setting the inhibit bit inside a strobe cannot trip the check
  strobe_on_a: assert property (!q.inhibit && q.ale_cnt < ALE_HIGH_CYC |=> ale_o)
    else $error("strobe missing");
  strobe_width_a: assert property (!q.inhibit && q.ale_cnt >= ALE_HIGH_CYC |=> !ale_o)
    else $error("strobe wider than its high time");
  pin_route_a: assert property (q.pinsel[0] && $stable(q.pinsel[0]) |=> p1_o[0] == $past(pwm_w[0]) && !p1_oe_n_o[0])
    else $error("enabled pin not driven by modulator");
  pin_gpio_a: assert property (!q.pinsel[7] |=> p1_o[7] == $past(gpio_out_i[7]))
    else $error("disabled pin not routed to port latch");
  res_write_a: assert property (wr && idx == IDX_CTRL[3] |=> q.ctrl[3].res5 == $past(wb_i.dat[RES_BIT]))
    else $error("resolution bit not written");
  slow_tick_a: assert property (tick_w[5] && q.ctrl[5].pre == 2'h3 |=> (!tick_w[5] || q.ctrl[5].pre != 2'h3) [*7])
    else $error("divide by 4 ticks too often");
  fast_tick_a: assert property (q.ctrl[2].pre == 2'h0 |-> tick_w[2])
    else $error("doubling code does not tick every clock");
  ack_once_a: assert property (wb_o.ack |=> !wb_o.ack)
    else $error("ack held longer than one cycle");

  inhibit_c: cover property (q.inhibit ##1 !ale_o [*8]);
  pwm_pin_c: cover property (q.pinsel[1] && p1_o[1] ##1 !p1_o[1]);
  wb_write_c: cover property (wr && idx == IDX_DUTY[0]);
endmodule // pwm_top

// *** design/pwm_pkg.sv ***
// Function
// - inhibit bit 0 of system control register suppresses the address latch strobe
// - each channel holds an 8-bit duty value setting pulse length per frame
// - 5-bit resolution uses only the five low duty bits
// - duty value is compared with a free-running frame counter to drive the pin
// - pin function select bit routes port 1 pin to modulator when 1; resets 0
// - resolution select bit set means 5-bit, clear means 8-bit; resets 0
// - two-bit prescaler codes 00..11 divide by 0.5, 1, 2, 4; resets 00
package pwm_pkg;
  localparam int NUM_CH = 8;
  localparam int CLK_PERIOD_NS = 4;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PINSEL = 8'h9b;
  localparam logic [7:0] IDX_SYSCTL = 8'hbf;
  localparam logic [7:0][7:0] IDX_CTRL = {8'hde, 8'hdd, 8'hdc, 8'hdb, 8'hd6, 8'hd5, 8'hd4, 8'hd3};
  localparam logic [7:0][7:0] IDX_DUTY = {8'hbe, 8'hbd, 8'hbc, 8'hbb, 8'hb6, 8'hb5, 8'hb4, 8'hb3};
  // field positions
  localparam int INHIBIT_BIT = 0;
  localparam int RES_BIT = 2;
  localparam int PRE_LSB = 0;
  localparam int PRE_MSB = 1;
  // values after reset
  localparam logic [7:0] PINSEL_RST = 8'h00;
  localparam logic INHIBIT_RST = 1'b0;
  localparam logic RES_RST = 1'b0;
  localparam logic [1:0] PRE_RST = 2'h0;
  localparam logic [7:0] DUTY_RST = 8'h00;
  // frame lengths
  localparam logic [7:0] FRAME5_LAST = 8'h1f;
  localparam logic [7:0] FRAME8_LAST = 8'hff;
  // clk_i runs at twice the oscillator rate so the 0.5 divisor is one tick per clock
  localparam int CLK_PER_OSC = 2;
  localparam int ALE_STROBE_OSC = 6;
  localparam int ALE_HIGH_OSC = 2;
  localparam logic [3:0] ALE_PERIOD_LAST = 4'(ALE_STROBE_OSC * CLK_PER_OSC - 1);
  localparam logic [3:0] ALE_HIGH_CYC = 4'(ALE_HIGH_OSC * CLK_PER_OSC);
  // prescaler code to divider mask, ticks every 1, 2, 4, 8 clocks
  localparam logic [3:0][2:0] PRE_MASK = {3'h7, 3'h3, 3'h1, 3'h0};

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic res5;
    logic [1:0] pre;
  } ch_ctrl_s;
endpackage

// *** design/pwm_channel.sv ***
`timescale 1ns/100ps
module pwm_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire pwm_pkg::ch_ctrl_s ctrl_i,
  input wire logic [7:0] duty_i,
  output logic pwm_o
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] duty;
    logic res5;
    logic pwm;
  } ch_state_s;

  ch_state_s q;
  ch_state_s n;
  logic frame_end;
  logic [7:0] eff_duty;

  always_comb begin
    n = q;
    frame_end = q.cnt == (q.res5 ? FRAME5_LAST : FRAME8_LAST);
    eff_duty = q.res5 ? {3'h0, q.duty[4:0]} : q.duty;
    if (tick_i) begin
      if (frame_end) begin
        n.cnt = 8'h00;
        n.duty = duty_i;
        n.res5 = ctrl_i.res5;
      end else begin
        n.cnt = q.cnt + 8'h01;
      end
    end
    n.pwm = q.cnt < eff_duty;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.duty <= DUTY_RST;
      q.res5 <= RES_RST;
    end else begin
      q <= n;
    end
  end

  assign pwm_o = q.pwm;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wrap_short_a: assert property (tick_i && q.res5 && q.cnt == 8'h1f |=> q.cnt == 8'h00)
    else $error("5-bit frame did not wrap at 32");
  wrap_long_a: assert property (tick_i && !q.res5 && q.cnt == 8'hff |=> q.cnt == 8'h00)
    else $error("8-bit frame did not wrap at 256");
  low_bits_a: assert property (q.res5 |=> pwm_o == ($past(q.cnt) < {3'h0, $past(q.duty[4:0])}))
    else $error("5-bit output used upper duty bits");
  compare_a: assert property (!q.res5 |=> pwm_o == ($past(q.cnt) < $past(q.duty)))
    else $error("output does not follow counter compare");
  duty_hold_a: assert property (!(tick_i && frame_end) |=> $stable(q.duty))
    else $error("duty changed inside a frame");
  duty_load_a: assert property (tick_i && frame_end |=> q.duty == $past(duty_i))
    else $error("duty not loaded at frame start");
  frame_c: cover property (tick_i && frame_end ##1 pwm_o [*2]);
endmodule // pwm_channel

// *** tb/pwm_load.sv ***
`timescale 1ns/100ps
module pwm_load (
  input wire logic [7:0] drive_i,
  input wire logic [7:0] oe_n_i,
  output logic [7:0] pad_o
);
  // weak pull-up: a released pin reads high, never the last driven level
  assign pad_o = (drive_i & ~oe_n_i) | oe_n_i;
endmodule // pwm_load

// *** tb/multichannel_pwm_with_ale_inhibit_test.sv ***
`timescale 1ns/100ps
module multichannel_pwm_with_ale_inhibit_test;
  import pwm_pkg::*;
  logic clk_i, rst_i, ale_o;
  wb_req_s wb_i;
  wb_rsp_s wb_o;
  logic [7:0] p1_i, p1_o, p1_oe_n_o, gpio_out_i, gpio_oe_n_i, gpio_in_o;
  logic [31:0] rd;
  int n_errors = 0;
  int checks = 0;
  int cyc_n = 0;
  int ale_n;
  int cnt [8];

  pwm_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .p1_i(p1_i), .p1_o(p1_o),
    .p1_oe_n_o(p1_oe_n_o), .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i), .gpio_in_o(gpio_in_o),
    .ale_o(ale_o));
  pwm_load load (.drive_i(p1_o), .oe_n_i(p1_oe_n_o), .pad_o(p1_i));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until ack is sampled high, then released for at least a cycle
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    rd = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic count(input int n);
    cnt = '{default: 0};
    ale_n = 0;
    repeat (n) begin
      @(posedge clk_i);
      ale_n += ale_o;
      foreach (cnt[i]) cnt[i] += p1_i[i];
    end
  endtask

  // ceiling well above the roughly 3000 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    gpio_out_i = 8'h5a;
    gpio_oe_n_i = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(p1_oe_n_o, 8'hff);
    rchk(IDX_PINSEL, PINSEL_RST);
    rchk(IDX_SYSCTL, 8'h00);
    for (int i = 0; i < NUM_CH; i++) begin
      rchk(IDX_CTRL[i], 8'h00);
      rchk(IDX_DUTY[i], DUTY_RST);
    end
    rchk(8'h10, 8'h00);
    repeat (3) @(posedge clk_i);
    chk(p1_i, 8'h5a);
    chk(gpio_in_o, 8'h5a);
    gpio_oe_n_i <= 8'hff;
    repeat (4) @(posedge clk_i);
    chk(p1_i, 8'hff);
    $display("test reset and io done");
    // top duty bits set so 5-bit mode must drop them
    for (int i = 0; i < NUM_CH; i++) begin
      wb(1'b1, IDX_CTRL[i], 8'hfc);
      rchk(IDX_CTRL[i], 8'h04);
      wb(1'b1, IDX_DUTY[i], 8'(8'he1 + i));
      rchk(IDX_DUTY[i], 8'(8'he1 + i));
    end
    wb(1'b1, IDX_PINSEL, 8'hff);
    rchk(IDX_PINSEL, 8'hff);
    repeat (70) @(posedge clk_i);
    count(32);
    foreach (cnt[i]) chk(cnt[i], i + 1);
    chk(p1_oe_n_o, 8'h00);
    $display("test 5-bit channels done");
    // code 00 runs only at the nominal sim clock, not a real fast crystal
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, IDX_CTRL[0], 8'(4 | p));
      wb(1'b1, IDX_DUTY[0], 8'h03);
      repeat (64 << p) @(posedge clk_i);
      count(32 << p);
      chk(cnt[0], 3 << p);
    end
    wb(1'b1, IDX_CTRL[0], 8'h00);
    wb(1'b1, IDX_DUTY[0], 8'h23);
    repeat (600) @(posedge clk_i);
    count(256);
    chk(cnt[0], 32'h23);
    $display("test prescale and 8-bit done");
    count(24);
    chk(ale_n, 8);
    wb(1'b1, IDX_SYSCTL, 8'h01);
    rchk(IDX_SYSCTL, 8'h01);
    count(24);
    chk(ale_n, 0);
    $display("test strobe done");
    test_done();
  end
endmodule // multichannel_pwm_with_ale_inhibit_test
